// ===== src/command_pkg.sv
// Shared constants for the control command handler and its word store.
package command_pkg;

  // ---------------------------------------------------------------------------
  // Shared word space.
  // ---------------------------------------------------------------------------
  localparam int DB_WORDS = 5000;
  localparam int DB_AW = 13;
  localparam int DW = 16;

  // ---------------------------------------------------------------------------
  // Register locations as seen from the serial network.
  // ---------------------------------------------------------------------------
  localparam logic [15:0] CTRL_CMD_ADDR = 16'h1A90;
  localparam logic [15:0] CTRL_CMD_ALIAS = 16'h1E78;
  localparam logic [15:0] CTRL_SPARE_FIRST = 16'h1A91;
  localparam logic [15:0] CTRL_SPARE_LAST = 16'h1B57;
  localparam logic [15:0] CTRL_CMD_RESET = 16'h0000;
  localparam logic [15:0] SPARE_READ_VALUE = 16'h0000;

  // ---------------------------------------------------------------------------
  // Command codes and transfer result codes.
  // ---------------------------------------------------------------------------
  localparam logic [15:0] CMD_CFG_WARM = 16'h270D;
  localparam logic [15:0] CMD_WARM = 16'h270E;
  localparam logic [15:0] CMD_COLD = 16'h270F;
  localparam logic [15:0] RES_OK = 16'h0000;
  localparam logic [15:0] RES_GENERAL = 16'hFFFF;
  localparam logic [15:0] RES_PORT1 = 16'hFFFE;
  localparam logic [15:0] RES_PORT2 = 16'hFFFD;
  localparam logic [1:0] XFER_OK = 2'h0;
  localparam logic [1:0] XFER_GENERAL = 2'h1;
  localparam logic [1:0] XFER_PORT1 = 2'h2;

  // ---------------------------------------------------------------------------
  // Serial function codes and exception codes.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] FC_RD_COILS = 8'h01;
  localparam logic [7:0] FC_RD_INPUTS = 8'h02;
  localparam logic [7:0] FC_RD_HOLDING = 8'h03;
  localparam logic [7:0] FC_RD_INPUT_REG = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_REG = 8'h06;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_WR_COILS = 8'h0F;
  localparam logic [7:0] FC_WR_REGS = 8'h10;
  localparam logic [7:0] FC_MASK_WR = 8'h16;
  localparam logic [7:0] FC_RD_WR_REGS = 8'h17;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;

endpackage

// ===== src/module_control_command.sv
// Serial slave request handler with control command register and shared word space.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Control register at 6800 acts only on codes 9997, 9998, 9999.
// - Code 9997 copies configuration to the host, then warm boots.
// - Code 9998 warm boots with no configuration transfer.
// - Code 9999 cold boots.
// - After warm or cold boot the control register reads zero; not for 9997.
// - After 9997 the register holds 0, -1, -2 or -3 as transfer result.
// - Slave accepts function codes 1, 2, 3, 4, 5, 6, 8, 15, 16.
// - Pass-through forwards writes 5, 6, 15, 16, 22, 23 to the host.
// - A 5000-word space is shared by host and network, independently.
module module_control_command #(
  parameter int DB_WORDS = command_pkg::DB_WORDS
) (
  input wire logic clk_sys, // System clock, 10 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic req_valid, // Parsed slave request present.
  output logic req_ready, // Request taken while high with valid.
  input wire logic [7:0] req_func, // Function code of the request.
  input wire logic [15:0] req_addr, // Word address of the request.
  input wire logic [15:0] req_data, // Write data or diagnostic data.
  output logic resp_valid, // Answer present.
  input wire logic resp_ready, // Answer taken while high with valid.
  output logic [7:0] resp_exc, // Exception code, zero for a normal answer.
  output logic [15:0] resp_data, // Read data or echoed write data.
  input wire logic passthru_en, // Pass-through mode configured.
  output logic pt_valid, // Forwarded write present for the host.
  input wire logic pt_ready, // Host takes the forwarded write.
  output logic [7:0] pt_func, // Function code of the forwarded write.
  output logic [15:0] pt_addr, // Address of the forwarded write.
  output logic [15:0] pt_data, // Data of the forwarded write.
  input wire logic host_en, // Host access to the shared space.
  input wire logic host_we, // Host write when high, read when low.
  input wire logic [12:0] host_addr, // Host word address.
  input wire logic [15:0] host_wdata, // Host write data.
  output logic [15:0] host_rdata, // Host read data, one cycle after access.
  output logic cfg_xfer_req, // Configuration copy to host requested.
  input wire logic cfg_xfer_done, // Host finished the configuration copy.
  input wire logic [1:0] cfg_xfer_status, // Result of the copy.
  output logic warm_boot, // One-cycle warm boot pulse.
  output logic cold_boot, // One-cycle cold boot pulse.
  output logic cmd_busy // Configuration copy in progress.
);

  // ---------------------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    REQ_IDLE,
    REQ_READ,
    REQ_PASS,
    REQ_RESP
  } req_state_e;

  typedef enum logic [0:0] {
    CMD_IDLE,
    CMD_XFER
  } cmd_state_e;

  typedef struct packed {
    req_state_e req_st;
    cmd_state_e cmd_st;
    logic [15:0] cmd_code;
    logic resp_valid;
    logic [7:0] resp_exc;
    logic [15:0] resp_data;
    logic pt_valid;
    logic [7:0] pt_func;
    logic [15:0] pt_addr;
    logic [15:0] pt_data;
    logic cfg_xfer_req;
    logic warm_boot;
    logic cold_boot;
  } cmd_state_s;

  cmd_state_s st_reg;
  cmd_state_s st_next;

  word_port_if #(.AW(command_pkg::DB_AW), .DW(command_pkg::DW)) words ();

  // ---------------------------------------------------------------------------
  // Decoding helpers.
  // ---------------------------------------------------------------------------
  function automatic logic is_slave_func(input logic [7:0] f);
    unique case (f)
      command_pkg::FC_RD_COILS, command_pkg::FC_RD_INPUTS,
      command_pkg::FC_RD_HOLDING, command_pkg::FC_RD_INPUT_REG,
      command_pkg::FC_WR_COIL, command_pkg::FC_WR_REG,
      command_pkg::FC_DIAG, command_pkg::FC_WR_COILS,
      command_pkg::FC_WR_REGS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic is_pass_write(input logic [7:0] f);
    unique case (f)
      command_pkg::FC_WR_COIL, command_pkg::FC_WR_REG,
      command_pkg::FC_WR_COILS, command_pkg::FC_WR_REGS,
      command_pkg::FC_MASK_WR, command_pkg::FC_RD_WR_REGS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic is_write(input logic [7:0] f);
    return (f == command_pkg::FC_WR_COIL) || (f == command_pkg::FC_WR_REG) ||
      (f == command_pkg::FC_WR_COILS) || (f == command_pkg::FC_WR_REGS);
  endfunction

  function automatic logic [15:0] result_code(input logic [1:0] s);
    unique case (s)
      command_pkg::XFER_OK: return command_pkg::RES_OK;
      command_pkg::XFER_GENERAL: return command_pkg::RES_GENERAL;
      command_pkg::XFER_PORT1: return command_pkg::RES_PORT1;
      default: return command_pkg::RES_PORT2;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // Address classes of the incoming request.
  // ---------------------------------------------------------------------------
  logic in_db;
  logic in_ctrl;
  logic in_spare;
  logic req_take;

  // The table location and the network alias both reach the control word.
  assign in_db = {16'h0000, req_addr} < 32'(DB_WORDS);
  assign in_ctrl = (req_addr == command_pkg::CTRL_CMD_ADDR) ||
    (req_addr == command_pkg::CTRL_CMD_ALIAS);
  assign in_spare = (req_addr >= command_pkg::CTRL_SPARE_FIRST) &&
    (req_addr <= command_pkg::CTRL_SPARE_LAST);
  assign req_ready = (st_reg.req_st == REQ_IDLE);
  assign req_take = req_valid && req_ready;

  // ---------------------------------------------------------------------------
  // Next-state logic.
  // ---------------------------------------------------------------------------
  // Serves one word per request, runs the command sequence and the store port.
  always_comb begin
    st_next = st_reg;
    st_next.warm_boot = 1'b0;
    st_next.cold_boot = 1'b0;
    words.a_en = 1'b0;
    words.a_we = 1'b0;
    words.a_addr = req_addr[command_pkg::DB_AW-1:0];
    words.a_wdata = req_data;

    // Finishing a configuration copy leaves the result and warm boots.
    if (st_reg.cmd_st == CMD_XFER && cfg_xfer_done) begin
      st_next.cfg_xfer_req = 1'b0;
      st_next.cmd_code = result_code(cfg_xfer_status);
      st_next.warm_boot = 1'b1;
      st_next.cmd_st = CMD_IDLE;
    end

    unique case (st_reg.req_st)
      REQ_IDLE: begin
        if (req_take) begin
          st_next.resp_exc = command_pkg::EXC_NONE;
          st_next.resp_data = req_data;
          if (passthru_en && is_pass_write(req_func)) begin
            // The host receives the write; the local space is untouched.
            st_next.pt_valid = 1'b1;
            st_next.pt_func = req_func;
            st_next.pt_addr = req_addr;
            st_next.pt_data = req_data;
            st_next.req_st = REQ_PASS;
          end else if (!is_slave_func(req_func)) begin
            st_next.resp_exc = command_pkg::EXC_ILLEGAL_FUNC;
            st_next.resp_valid = 1'b1;
            st_next.req_st = REQ_RESP;
          end else if (req_func == command_pkg::FC_DIAG) begin
            // Diagnostics echo the data word back.
            st_next.resp_valid = 1'b1;
            st_next.req_st = REQ_RESP;
          end else if (in_db) begin
            words.a_en = 1'b1;
            words.a_we = is_write(req_func);
            if (is_write(req_func)) begin
              st_next.resp_valid = 1'b1;
              st_next.req_st = REQ_RESP;
            end else begin
              st_next.req_st = REQ_READ;
            end
          end else if (in_ctrl) begin
            st_next.resp_valid = 1'b1;
            st_next.req_st = REQ_RESP;
            if (!is_write(req_func)) begin
              st_next.resp_data = st_reg.cmd_code;
            end else if (st_reg.cmd_st == CMD_IDLE) begin
              // A write during a copy is answered but dropped.
              st_next.cmd_code = req_data;
              unique case (req_data)
                command_pkg::CMD_CFG_WARM: begin
                  st_next.cfg_xfer_req = 1'b1;
                  st_next.cmd_st = CMD_XFER;
                end
                command_pkg::CMD_WARM: begin
                  st_next.warm_boot = 1'b1;
                  st_next.cmd_code = command_pkg::CTRL_CMD_RESET;
                end
                command_pkg::CMD_COLD: begin
                  st_next.cold_boot = 1'b1;
                  st_next.cmd_code = command_pkg::CTRL_CMD_RESET;
                end
                default: begin
                  st_next.cmd_code = req_data;
                end
              endcase
            end
          end else if (in_spare) begin
            // Unused command words read as zero and ignore writes.
            st_next.resp_data = command_pkg::SPARE_READ_VALUE;
            st_next.resp_valid = 1'b1;
            st_next.req_st = REQ_RESP;
          end else begin
            st_next.resp_exc = command_pkg::EXC_ILLEGAL_ADDR;
            st_next.resp_valid = 1'b1;
            st_next.req_st = REQ_RESP;
          end
        end
      end
      REQ_READ: begin
        st_next.resp_data = words.a_rdata;
        st_next.resp_valid = 1'b1;
        st_next.req_st = REQ_RESP;
      end
      REQ_PASS: begin
        if (pt_ready) begin
          st_next.pt_valid = 1'b0;
          st_next.resp_valid = 1'b1;
          st_next.req_st = REQ_RESP;
        end
      end
      REQ_RESP: begin
        if (resp_ready) begin
          st_next.resp_valid = 1'b0;
          st_next.req_st = REQ_IDLE;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // State register.
  // ---------------------------------------------------------------------------
  // The control word starts at zero so no command runs out of reset.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '{
        req_st: REQ_IDLE,
        cmd_st: CMD_IDLE,
        cmd_code: command_pkg::CTRL_CMD_RESET,
        default: '0
      };
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Shared word store and outputs.
  // ---------------------------------------------------------------------------
  // The host reaches the store on its own port, free of network timing.
  assign words.b_en = host_en;
  assign words.b_we = host_we;
  assign words.b_addr = host_addr;
  assign words.b_wdata = host_wdata;

  shared_word_ram #(
    .DEPTH(DB_WORDS),
    .AW(command_pkg::DB_AW),
    .DW(command_pkg::DW)
  ) u_ram (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .port(words.store)
  );

  assign host_rdata = words.b_rdata;
  assign resp_valid = st_reg.resp_valid;
  assign resp_exc = st_reg.resp_exc;
  assign resp_data = st_reg.resp_data;
  assign pt_valid = st_reg.pt_valid;
  assign pt_func = st_reg.pt_func;
  assign pt_addr = st_reg.pt_addr;
  assign pt_data = st_reg.pt_data;
  assign cfg_xfer_req = st_reg.cfg_xfer_req;
  assign warm_boot = st_reg.warm_boot;
  assign cold_boot = st_reg.cold_boot;
  assign cmd_busy = (st_reg.cmd_st == CMD_XFER);

endmodule

`default_nettype wire

// ===== src/shared_word_ram.sv
// Dual-port word store shared by the serial side and the host processor.
`timescale 1ns/1ns
`default_nettype none

module shared_word_ram #(
  parameter int DEPTH = command_pkg::DB_WORDS,
  parameter int AW = command_pkg::DB_AW,
  parameter int DW = command_pkg::DW
) (
  input wire logic clk_sys, // System clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  word_port_if.store port // Serial side on port a, host on port b.
);

  logic [DW-1:0] mem [DEPTH];

  typedef struct packed {
    logic [DW-1:0] a_rdata;
    logic [DW-1:0] b_rdata;
  } ram_state_s;

  ram_state_s st_reg;
  ram_state_s st_next;

  // Read data of both ports is registered; a write returns the old word.
  always_comb begin
    st_next = st_reg;
    if (port.a_en) begin
      st_next.a_rdata = mem[port.a_addr];
    end
    if (port.b_en) begin
      st_next.b_rdata = mem[port.b_addr];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Array writes; on a same-word collision the host port lands last.
  always_ff @(posedge clk_sys) begin
    if (port.a_en && port.a_we) begin
      mem[port.a_addr] <= port.a_wdata;
    end
    if (port.b_en && port.b_we) begin
      mem[port.b_addr] <= port.b_wdata;
    end
  end

  assign port.a_rdata = st_reg.a_rdata;
  assign port.b_rdata = st_reg.b_rdata;

endmodule

`default_nettype wire

// ===== src/word_port_if.sv
// Two-port connection between the command handler and its word store.
`timescale 1ns/1ns
`default_nettype none

interface word_port_if #(
  parameter int AW = command_pkg::DB_AW,
  parameter int DW = command_pkg::DW
);
  logic a_en;
  logic a_we;
  logic [AW-1:0] a_addr;
  logic [DW-1:0] a_wdata;
  logic [DW-1:0] a_rdata;
  logic b_en;
  logic b_we;
  logic [AW-1:0] b_addr;
  logic [DW-1:0] b_wdata;
  logic [DW-1:0] b_rdata;

  modport store (
    input a_en, a_we, a_addr, a_wdata, b_en, b_we, b_addr, b_wdata,
    output a_rdata, b_rdata
  );
  modport user (
    output a_en, a_we, a_addr, a_wdata, b_en, b_we, b_addr, b_wdata,
    input a_rdata, b_rdata
  );
endinterface

`default_nettype wire

// ===== verification/mcc_sva.sv
// Port checks for the control command handler.
`timescale 1ns/1ns
`default_nettype none

module mcc_sva (
  input wire logic clk_sys, // Clock.
  input wire logic arst_n, // Reset.
  input wire logic req_valid, // Request.
  input wire logic req_ready, // Taken.
  input wire logic [7:0] req_func, // Function.
  input wire logic [15:0] req_addr, // Address.
  input wire logic [15:0] req_data, // Data.
  input wire logic passthru_en, // Pass-through.
  input wire logic resp_valid, // Answer.
  input wire logic [7:0] resp_exc, // Exception.
  input wire logic pt_valid, // Forwarded.
  input wire logic [15:0] pt_data, // Forwarded data.
  input wire logic cfg_xfer_req, // Copy request.
  input wire logic cfg_xfer_done, // Copy done.
  input wire logic cmd_busy, // Copy busy.
  input wire logic warm_boot, // Warm pulse.
  input wire logic cold_boot // Cold pulse.
);
  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // A take that puts a new code into the control word.
  logic ctl_wr;
  logic take;
  assign take = req_valid && req_ready;
  assign ctl_wr = take && !passthru_en && !cmd_busy &&
    (req_func inside {8'h05, 8'h06, 8'h0F, 8'h10}) &&
    (req_addr == command_pkg::CTRL_CMD_ADDR || req_addr == command_pkg::CTRL_CMD_ALIAS);

  a_cold_made: assert property (
    ctl_wr && req_data == command_pkg::CMD_COLD |=> cold_boot ##1 !cold_boot)
    else $error("cold boot pulse missing");
  a_cold_cause: assert property (
    cold_boot |-> $past(ctl_wr && req_data == command_pkg::CMD_COLD))
    else $error("cold boot without its code");
  a_warm_made: assert property (
    ctl_wr && req_data == command_pkg::CMD_WARM |=> warm_boot ##1 !warm_boot)
    else $error("warm boot pulse missing");
  a_warm_cause: assert property (
    warm_boot |-> $past(ctl_wr && req_data == command_pkg::CMD_WARM) ||
    $past(cfg_xfer_done && cmd_busy))
    else $error("warm boot without cause");
  a_cfg_start: assert property (
    ctl_wr && req_data == command_pkg::CMD_CFG_WARM |=> cfg_xfer_req && cmd_busy && !warm_boot)
    else $error("copy not started");
  a_cfg_hold: assert property (
    cmd_busy && !cfg_xfer_done |=> cfg_xfer_req && cmd_busy)
    else $error("copy request dropped early");
  a_cfg_end: assert property (
    cmd_busy && cfg_xfer_done |=> !cfg_xfer_req && warm_boot ##1 !warm_boot)
    else $error("copy end without warm boot");
  a_bad_func: assert property (
    take && !(req_func inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0F, 8'h10})
    && !(passthru_en && req_func inside {8'h16, 8'h17}) |=> resp_valid && resp_exc == 8'h01)
    else $error("bad function not refused");
  a_pt_fwd: assert property (
    take && passthru_en && (req_func inside {8'h05, 8'h06, 8'h0F, 8'h10, 8'h16, 8'h17})
    |=> pt_valid && pt_data == $past(req_data) && !resp_valid &&
    (!warm_boot || $past(cmd_busy)) && !cold_boot)
    else $error("write not forwarded");
endmodule

bind module_control_command mcc_sva i_mcc_sva (
  .clk_sys(clk_sys), .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready),
  .req_func(req_func), .req_addr(req_addr), .req_data(req_data), .passthru_en(passthru_en),
  .resp_valid(resp_valid), .resp_exc(resp_exc), .pt_valid(pt_valid), .pt_data(pt_data),
  .cfg_xfer_req(cfg_xfer_req), .cfg_xfer_done(cfg_xfer_done), .cmd_busy(cmd_busy),
  .warm_boot(warm_boot), .cold_boot(cold_boot)
);

`default_nettype wire

// ===== verification/remote_master.sv
// Remote serial master that issues one-word requests.
`timescale 1ns/1ns
`default_nettype none

module remote_master (
  input wire logic clk_sys, // Clock.
  output logic req_valid, // Request.
  input wire logic req_ready, // Taken.
  output logic [7:0] req_func, // Function.
  output logic [15:0] req_addr, // Address.
  output logic [15:0] req_data, // Data.
  input wire logic resp_valid, // Answer.
  output logic resp_ready, // Answer taken.
  input wire logic [7:0] resp_exc, // Exception.
  input wire logic [15:0] resp_data // Answer word.
);
  // Idle state of the request lines.
  initial begin
    req_valid = 1'b0;
    resp_ready = 1'b0;
    req_func = 8'h00;
    req_addr = 16'h0000;
    req_data = 16'hFFFF;
  end

  // Holds a request until taken, then takes the answer after lag cycles.
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                      input int lag, output logic [7:0] e, output logic [15:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    #1 req_valid = 1'b1;
    req_func = f;
    req_addr = a;
    req_data = d;
    do @(posedge clk_sys); while (req_ready !== 1'b1 && ++n < 40);
    #1 req_valid = 1'b0;
    req_data = ~d; // Released data never keeps the last word.
    // The answer strobe rises one tick after an edge, like every other drive.
    repeat (lag) @(posedge clk_sys);
    if (lag > 0) #1;
    resp_ready = 1'b1;
    n = 0;
    do @(posedge clk_sys); while (resp_valid !== 1'b1 && ++n < 40);
    e = resp_exc;
    q = resp_data;
    #1 resp_ready = 1'b0;
  endtask
endmodule

`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the control command handler.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic clk_sys, arst_n, req_valid, req_ready, resp_valid, resp_ready, passthru_en, pt_valid;
  logic pt_ready, host_en, host_we, cfg_xfer_req, cfg_xfer_done, warm_boot, cold_boot, cmd_busy;
  logic [7:0] req_func, resp_exc, pt_func, e, pt_fn;
  logic [15:0] req_addr, req_data, resp_data, pt_addr, pt_data, host_wdata, host_rdata, pt_seen, q;
  logic [12:0] host_addr;
  logic [15:0] pt_ad;
  logic [1:0] cfg_xfer_status;
  logic [7:0] ok_f [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0F, 8'h10};
  logic [7:0] bad_f [4] = '{8'h07, 8'h16, 8'h17, 8'h2B};
  int fails = 0, n_tests = 0, n_warm = 0, n_cold = 0, cyc = 0;
  localparam logic [15:0] CA = command_pkg::CTRL_CMD_ADDR;

  module_control_command i_module_control_command (
    .clk_sys(clk_sys), .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_func(req_func), .req_addr(req_addr), .req_data(req_data), .resp_valid(resp_valid),
    .resp_ready(resp_ready), .resp_exc(resp_exc), .resp_data(resp_data),
    .passthru_en(passthru_en), .pt_valid(pt_valid), .pt_ready(pt_ready), .pt_func(pt_func),
    .pt_addr(pt_addr), .pt_data(pt_data), .host_en(host_en), .host_we(host_we),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .cfg_xfer_req(cfg_xfer_req), .cfg_xfer_done(cfg_xfer_done),
    .cfg_xfer_status(cfg_xfer_status), .warm_boot(warm_boot), .cold_boot(cold_boot),
    .cmd_busy(cmd_busy)
  );
  remote_master i_remote_master (
    .clk_sys(clk_sys), .req_valid(req_valid), .req_ready(req_ready), .req_func(req_func),
    .req_addr(req_addr), .req_data(req_data), .resp_valid(resp_valid),
    .resp_ready(resp_ready), .resp_exc(resp_exc), .resp_data(resp_data)
  );

  // Clock at 10 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Counts boot pulse cycles, keeps forwarded writes and cuts a hang short.
  always @(posedge clk_sys) begin
    if (warm_boot === 1'b1) n_warm++;
    if (cold_boot === 1'b1) n_cold++;
    if (pt_valid === 1'b1 && pt_ready === 1'b1) begin
      pt_seen <= pt_data;
      pt_fn <= pt_func;
      pt_ad <= pt_addr;
    end
    cyc++;
    if (cyc > 20000) begin
      fails++;
      stop_test();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("Checks: %0d, mismatches: %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic rq(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
    i_remote_master.xfer(f, a, d, 0, e, q);
  endtask

  // One host access; read data is valid when the task returns.
  task automatic host(input logic we, input logic [12:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1 host_en = 1'b1;
    host_we = we;
    host_addr = a;
    host_wdata = d;
    @(posedge clk_sys);
    #1 host_en = 1'b0;
  endtask

  task automatic t_data;
    chk({cfg_xfer_req, cmd_busy, warm_boot, cold_boot, resp_valid, pt_valid}, 16'h0000);
    rq(8'h03, CA, 16'h0000);
    chk(q, command_pkg::CTRL_CMD_RESET);
    rq(8'h06, 16'h000A, 16'hA55A);
    i_remote_master.xfer(8'h03, 16'h000A, 16'h0000, 3, e, q);
    chk(q, 16'hA55A);
    host(1'b0, 13'h000A, 16'h0000);
    chk(host_rdata, 16'hA55A);
    host(1'b1, 13'h1387, 16'h3C3C);
    rq(8'h04, 16'h1387, 16'h0000);
    chk(q, 16'h3C3C);
    rq(8'h06, 16'h1388, 16'h0001);
    chk(e, command_pkg::EXC_ILLEGAL_ADDR);
    rq(8'h06, command_pkg::CTRL_SPARE_LAST, 16'h0005);
    rq(8'h03, command_pkg::CTRL_SPARE_LAST, 16'h0000);
    chk(q, command_pkg::SPARE_READ_VALUE);
    foreach (ok_f[i]) begin
      rq(ok_f[i], 16'h000C, 16'h0001);
      chk(e, command_pkg::EXC_NONE);
    end
    foreach (bad_f[i]) begin
      rq(bad_f[i], 16'h000C, 16'h0001);
      chk(e, command_pkg::EXC_ILLEGAL_FUNC);
    end
  endtask

  task automatic t_boot;
    rq(8'h06, CA, command_pkg::CMD_WARM);
    repeat (2) @(posedge clk_sys);
    chk(16'(n_warm), 16'h0001);
    rq(8'h03, CA, 16'h0000);
    chk(q, command_pkg::CTRL_CMD_RESET);
    rq(8'h10, command_pkg::CTRL_CMD_ALIAS, command_pkg::CMD_COLD);
    repeat (2) @(posedge clk_sys);
    chk(16'(n_cold), 16'h0001);
    rq(8'h03, CA, 16'h0000);
    chk(q, command_pkg::CTRL_CMD_RESET);
    rq(8'h05, CA, 16'h1234);
    rq(8'h03, CA, 16'h0000);
    chk(q, 16'h1234);
    chk(16'(n_warm + n_cold + cmd_busy), 16'h0002);
  endtask

  task automatic t_cfg;
    logic [15:0] res [4];
    res = '{command_pkg::RES_OK, command_pkg::RES_GENERAL, command_pkg::RES_PORT1,
            command_pkg::RES_PORT2};
    for (int s = 0; s < 4; s++) begin
      rq(8'h06, CA, command_pkg::CMD_CFG_WARM);
      chk({cfg_xfer_req, cmd_busy}, 16'h0003);
      rq(8'h06, CA, command_pkg::CMD_COLD);
      rq(8'h03, CA, 16'h0000);
      chk(q, command_pkg::CMD_CFG_WARM);
      @(posedge clk_sys);
      #1 cfg_xfer_done = 1'b1;
      cfg_xfer_status = s[1:0];
      @(posedge clk_sys);
      #1 cfg_xfer_done = 1'b0;
      chk({cfg_xfer_req, cmd_busy}, 16'h0000);
      repeat (2) @(posedge clk_sys);
      chk(16'(n_warm * 4 + n_cold), 16'(9 + 4 * s));
      rq(8'h03, CA, 16'h0000);
      chk(q, res[s]);
    end
  endtask

  task automatic t_pt;
    passthru_en = 1'b1;
    pt_ready = 1'b1;
    rq(8'h06, CA, command_pkg::CMD_COLD);
    chk(pt_seen, command_pkg::CMD_COLD);
    chk(pt_fn, 8'h06);
    chk(pt_ad, CA);
    chk(q, command_pkg::CMD_COLD);
    rq(8'h17, 16'h000A, 16'h5AA5);
    chk(pt_seen, 16'h5AA5);
    chk(pt_ad, 16'h000A);
    chk(e, command_pkg::EXC_NONE);
    passthru_en = 1'b0;
    rq(8'h03, CA, 16'h0000);
    chk(q, command_pkg::RES_PORT2);
    rq(8'h03, 16'h000A, 16'h0000);
    chk(q, 16'hA55A);
    chk(16'(n_cold), 16'h0001);
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    arst_n = 1'b0;
    passthru_en = 1'b0;
    pt_ready = 1'b0;
    host_en = 1'b0;
    host_we = 1'b0;
    host_addr = 13'h0000;
    host_wdata = 16'h0000;
    cfg_xfer_done = 1'b0;
    cfg_xfer_status = 2'h0;
    repeat (5) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    t_data();
    t_boot();
    t_cfg();
    t_pt();
    stop_test();
  end
endmodule

`default_nettype wire
